// >>> srtc_core.sv
// Serial clock/calendar: three-wire command link and BCD timekeeping
//
// How it works
// RL1 - Time and date fields kept as BCD ranges
// RL2 - Single-byte and burst transfers both supported
// RL3 - Each transfer opens with a decoded command
// RL4 - Command bit 0 picks read or write
// RL5 - Zero writes the register, one reads it
// RL6 - Command bits 3..1 select the register
// RL7 - Addresses 0..7: time, date fields, guard
// RL8 - Upper bits 1011111 select burst transfer
// RL9 - Burst starts at zero; reads all eight, writes all but guard
// RL10 - Host avoids 1001xxx1 test commands
// RL11 - Seconds bit 7 halts the oscillator
// RL12 - Guard bit 7 refuses writes; others zero
// RL13 - Hours bit 7 selects 12 or 24
// RL14 - Hours bit 5 flags PM in 12-hour
// RL15 - Hours bit 5 is tens bit in 24-hour
// RL16 - Host sets halt and guard bits first
// RL17 - Host sends command before data byte
// RL18 - Fixed-zero bits always read back zero
// RL19 - Locked writes change nothing but guard
`timescale 1ns/1ns
`default_nettype none
module srtc_core
  import srtc_pkg::*;
#(
  parameter int SECOND_CYCLES_P = srtc_pkg::SECOND_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Serial link pins
  input wire logic transfer_enable_pin,
  input wire logic sclk,
  input wire logic sdata_in,
  output logic sdata_out,
  output logic sdata_oe
);
  import srtc_pkg::*;

  // ==========================================================================
  // Pin synchronisers
  srtc_pins_t pin_s1_ff, pin_s2_ff, pin_s3_ff;
  srtc_pins_t nxt_pin_s1;
  logic sclk_rise, sclk_fall;

  always_comb begin
    nxt_pin_s1 = '{enable: transfer_enable_pin, sclk: sclk, sdata: sdata_in};
    sclk_rise = pin_s2_ff.sclk & ~pin_s3_ff.sclk;
    sclk_fall = ~pin_s2_ff.sclk & pin_s3_ff.sclk;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      pin_s3_ff <= '0;
    end else begin
      pin_s1_ff <= nxt_pin_s1;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  // ==========================================================================
  // Register array and timekeeping
  logic [7:0] regs_ff [NUM_REGS];
  logic [7:0] nxt_regs [NUM_REGS];
  logic [PRESCALE_W-1:0] prescale_ff, nxt_prescale;
  srtc_wr_t wr_ff, nxt_wr;
  logic [7:0] step_val [NUM_FIELDS];
  logic [7:0] step_lo [NUM_FIELDS];
  logic [7:0] step_hi [NUM_FIELDS];
  logic [7:0] step_nxt [NUM_FIELDS];
  logic step_wrap [NUM_FIELDS];
  logic halted, hour12, pm, tick, day_roll, leap;
  logic [7:0] hour_val, month_days;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_FIELDS; gi++) begin : g_step
      srtc_bcd_step u_step (
        .value(step_val[gi]),
        .lo(step_lo[gi]),
        .hi(step_hi[gi]),
        .nxt(step_nxt[gi]),
        .wrap(step_wrap[gi])
      );
    end
  endgenerate

  always_comb begin
    halted = regs_ff[ADDR_SECONDS][OSC_HALT_BIT]; // RL11
    hour12 = regs_ff[ADDR_HOURS][HOUR12_BIT]; // RL13
    pm = hour12 & regs_ff[ADDR_HOURS][PM_FLAG_BIT]; // RL14
    hour_val = hour12 ? {3'b000, regs_ff[ADDR_HOURS][4:0]}
                      : {2'b00, regs_ff[ADDR_HOURS][5:0]}; // RL15
    leap = (2'({regs_ff[ADDR_YEAR][4], 1'b0}) + regs_ff[ADDR_YEAR][1:0]) == 2'b00;
    case (regs_ff[ADDR_MONTH][4:0])
      5'h02: month_days = leap ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: month_days = 8'h30;
      default: month_days = 8'h31;
    endcase
    // Per-field BCD bounds
    step_val[ADDR_SECONDS] = {1'b0, regs_ff[ADDR_SECONDS][6:0]};
    step_lo[ADDR_SECONDS] = BCD_ZERO;
    step_hi[ADDR_SECONDS] = SEC_MAX; // RL1
    step_val[ADDR_MINUTES] = {1'b0, regs_ff[ADDR_MINUTES][6:0]};
    step_lo[ADDR_MINUTES] = BCD_ZERO;
    step_hi[ADDR_MINUTES] = SEC_MAX;
    step_val[ADDR_HOURS] = hour_val;
    step_lo[ADDR_HOURS] = hour12 ? BCD_ONE : BCD_ZERO;
    step_hi[ADDR_HOURS] = hour12 ? HOUR12_MAX : HOUR24_MAX;
    step_val[ADDR_DAY_OF_MONTH] = {2'b00, regs_ff[ADDR_DAY_OF_MONTH][5:0]};
    step_lo[ADDR_DAY_OF_MONTH] = BCD_ONE;
    step_hi[ADDR_DAY_OF_MONTH] = month_days;
    step_val[ADDR_MONTH] = {3'b000, regs_ff[ADDR_MONTH][4:0]};
    step_lo[ADDR_MONTH] = BCD_ONE;
    step_hi[ADDR_MONTH] = MONTH_MAX;
    step_val[ADDR_WEEKDAY] = {4'h0, regs_ff[ADDR_WEEKDAY][3:0]};
    step_lo[ADDR_WEEKDAY] = BCD_ONE;
    step_hi[ADDR_WEEKDAY] = WEEKDAY_MAX;
    step_val[ADDR_YEAR] = regs_ff[ADDR_YEAR];
    step_lo[ADDR_YEAR] = BCD_ZERO;
    step_hi[ADDR_YEAR] = YEAR_MAX;

    tick = ~halted && (prescale_ff == PRESCALE_W'(SECOND_CYCLES_P - 1));
    nxt_prescale = (halted || tick) ? '0 : prescale_ff + PRESCALE_W'(1); // RL11
    day_roll = hour12 ? (pm && hour_val == HOUR12_LAST) : step_wrap[ADDR_HOURS];

    for (int i = 0; i < NUM_REGS; i++) begin
      nxt_regs[i] = regs_ff[i];
    end
    if (tick) begin
      nxt_regs[ADDR_SECONDS] = {1'b0, step_nxt[ADDR_SECONDS][6:0]};
      if (step_wrap[ADDR_SECONDS]) begin
        nxt_regs[ADDR_MINUTES] = step_nxt[ADDR_MINUTES];
        if (step_wrap[ADDR_MINUTES]) begin
          if (hour12) begin
            nxt_regs[ADDR_HOURS] = {2'b10, pm ^ (hour_val == HOUR12_LAST),
                                    step_nxt[ADDR_HOURS][4:0]}; // RL14
          end else begin
            nxt_regs[ADDR_HOURS] = {2'b00, step_nxt[ADDR_HOURS][5:0]}; // RL15
          end
          if (day_roll) begin
            nxt_regs[ADDR_DAY_OF_MONTH] = step_nxt[ADDR_DAY_OF_MONTH];
            nxt_regs[ADDR_WEEKDAY] = step_nxt[ADDR_WEEKDAY];
            if (step_wrap[ADDR_DAY_OF_MONTH]) begin
              nxt_regs[ADDR_MONTH] = step_nxt[ADDR_MONTH];
              if (step_wrap[ADDR_MONTH]) begin
                nxt_regs[ADDR_YEAR] = step_nxt[ADDR_YEAR];
              end
            end
          end
        end
      end
    end
    // Host write overrides the count in the same cycle
    if (wr_ff.valid) begin
      nxt_regs[wr_ff.addr] = wr_ff.data & FIELD_MASK[wr_ff.addr]; // RL18
      if (wr_ff.addr == ADDR_SECONDS) begin
        nxt_prescale = '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      prescale_ff <= '0;
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_ff[i] <= REG_RESET[i];
      end
    end else begin
      prescale_ff <= nxt_prescale;
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_ff[i] <= nxt_regs[i];
      end
    end
  end

  // ==========================================================================
  // Serial command and data engine
  srtc_state_t state_ff, nxt_state;
  logic [7:0] shift_ff, nxt_shift;
  logic [2:0] bit_cnt_ff, nxt_bit_cnt;
  logic [2:0] addr_ff, nxt_addr;
  logic burst_ff, nxt_burst;
  logic sdata_out_ff, nxt_sdata_out;
  logic sdata_oe_ff, nxt_sdata_oe;
  logic [7:0] in_byte;
  logic [2:0] next_addr;
  logic wr_allowed;

  always_comb begin
    nxt_state = state_ff;
    nxt_shift = shift_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_addr = addr_ff;
    nxt_burst = burst_ff;
    nxt_sdata_out = sdata_out_ff;
    nxt_sdata_oe = sdata_oe_ff;
    nxt_wr = '0;
    in_byte = {pin_s2_ff.sdata, shift_ff[7:1]}; // Bit 0 arrives first
    next_addr = burst_ff ? addr_ff + 3'h1 : addr_ff; // RL9
    wr_allowed = (~regs_ff[ADDR_WRITE_GUARD][GUARD_BIT] || addr_ff == ADDR_WRITE_GUARD)
                 && ~(burst_ff && addr_ff == ADDR_WRITE_GUARD); // RL12 RL19

    if (!pin_s2_ff.enable) begin
      nxt_state = ST_IDLE;
      nxt_sdata_oe = 1'b0;
      nxt_sdata_out = 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          nxt_state = ST_CMD;
          nxt_bit_cnt = 3'h0;
          nxt_shift = 8'h00;
        end
        ST_CMD: begin
          if (sclk_rise) begin
            nxt_shift = in_byte;
            nxt_bit_cnt = bit_cnt_ff + 3'h1;
            if (bit_cnt_ff == 3'h7) begin // RL3
              nxt_burst = (in_byte[7:1] == BURST_CODE); // RL8
              nxt_addr = nxt_burst ? ADDR_SECONDS : in_byte[3:1]; // RL6 RL7 RL9
              if (!in_byte[7] || (in_byte[7:4] == TEST_CODE && in_byte[DIR_BIT])) begin
                nxt_state = ST_HOLD; // RL10
              end else if (in_byte[DIR_BIT]) begin // RL4 RL5
                nxt_state = ST_READ;
                nxt_shift = regs_ff[nxt_addr];
              end else begin
                nxt_state = ST_WRITE;
              end
            end
          end
        end
        ST_WRITE: begin
          if (sclk_rise) begin
            nxt_shift = in_byte;
            nxt_bit_cnt = bit_cnt_ff + 3'h1;
            if (bit_cnt_ff == 3'h7) begin
              nxt_wr = '{valid: wr_allowed, addr: addr_ff, data: in_byte}; // RL5 RL12
              nxt_addr = next_addr;
              // Burst write ends at the guard byte
              if (!burst_ff || addr_ff == ADDR_WRITE_GUARD) begin
                nxt_state = ST_HOLD; // RL2
              end
            end
          end
        end
        ST_READ: begin
          // Bits leave on the falling clock edge
          if (sclk_fall) begin
            nxt_sdata_oe = 1'b1;
            nxt_sdata_out = shift_ff[0];
            nxt_bit_cnt = bit_cnt_ff + 3'h1;
            if (bit_cnt_ff == 3'h7) begin // RL2 RL9
              nxt_addr = next_addr;
              nxt_shift = regs_ff[next_addr];
            end else begin
              nxt_shift = {1'b0, shift_ff[7:1]};
            end
          end
        end
        ST_HOLD: begin
          nxt_state = ST_HOLD;
        end
        default: begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= ST_IDLE;
      shift_ff <= 8'h00;
      bit_cnt_ff <= 3'h0;
      addr_ff <= 3'h0;
      burst_ff <= 1'b0;
      sdata_out_ff <= 1'b0;
      sdata_oe_ff <= 1'b0;
      wr_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      shift_ff <= nxt_shift;
      bit_cnt_ff <= nxt_bit_cnt;
      addr_ff <= nxt_addr;
      burst_ff <= nxt_burst;
      sdata_out_ff <= nxt_sdata_out;
      sdata_oe_ff <= nxt_sdata_oe;
      wr_ff <= nxt_wr;
    end
  end

  assign sdata_out = sdata_out_ff;
  assign sdata_oe = sdata_oe_ff;
endmodule : srtc_core
`default_nettype wire

// >>> srtc_pkg.sv
// Shared constants, types and register layout of the serial clock/calendar
`default_nettype none
package srtc_pkg;
  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SECOND_MS = 1000;
  localparam int SECOND_CYCLES = SECOND_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int PRESCALE_W = 27;

  // ==========================================================================
  // Register addresses
  localparam logic [2:0] ADDR_SECONDS = 3'h0;
  localparam logic [2:0] ADDR_MINUTES = 3'h1;
  localparam logic [2:0] ADDR_HOURS = 3'h2;
  localparam logic [2:0] ADDR_DAY_OF_MONTH = 3'h3;
  localparam logic [2:0] ADDR_MONTH = 3'h4;
  localparam logic [2:0] ADDR_WEEKDAY = 3'h5;
  localparam logic [2:0] ADDR_YEAR = 3'h6;
  localparam logic [2:0] ADDR_WRITE_GUARD = 3'h7;
  localparam int NUM_REGS = 8;
  localparam int NUM_FIELDS = 7;

  // ==========================================================================
  // Field positions
  localparam int OSC_HALT_BIT = 7;
  localparam int HOUR12_BIT = 7;
  localparam int PM_FLAG_BIT = 5;
  localparam int GUARD_BIT = 7;
  localparam int DIR_BIT = 0;

  // ==========================================================================
  // Command byte codes
  localparam logic [6:0] BURST_CODE = 7'h5f;
  localparam logic [3:0] TEST_CODE = 4'h9;

  // ==========================================================================
  // Reset values, writable-bit masks, BCD limits (index = address)
  localparam logic [7:0][7:0] REG_RESET = {
    8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h80};
  localparam logic [7:0][7:0] FIELD_MASK = {
    8'h80, 8'hff, 8'h0f, 8'h1f, 8'h3f, 8'hbf, 8'h7f, 8'hff};
  localparam logic [7:0] SEC_MAX = 8'h59;
  localparam logic [7:0] HOUR12_MAX = 8'h12;
  localparam logic [7:0] HOUR24_MAX = 8'h23;
  localparam logic [7:0] HOUR12_LAST = 8'h11;
  localparam logic [7:0] MONTH_MAX = 8'h12;
  localparam logic [7:0] WEEKDAY_MAX = 8'h07;
  localparam logic [7:0] YEAR_MAX = 8'h99;
  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] BCD_ONE = 8'h01;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CMD = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ = 3'b011,
    ST_HOLD = 3'b100
  } srtc_state_t;

  typedef struct packed {
    logic enable;
    logic sclk;
    logic sdata;
  } srtc_pins_t;

  typedef struct packed {
    logic valid;
    logic [2:0] addr;
    logic [7:0] data;
  } srtc_wr_t;
endpackage : srtc_pkg
`default_nettype wire

// >>> srtc_bcd_step.sv
// Two-digit BCD increment with wrap to a lower bound
`timescale 1ns/1ns
`default_nettype none
module srtc_bcd_step (
  // Current value and limits
  input wire logic [7:0] value,
  input wire logic [7:0] lo,
  input wire logic [7:0] hi,
  // Result
  output logic [7:0] nxt,
  output logic wrap
);
  logic [7:0] inc;

  always_comb begin
    wrap = (value >= hi);
    if (value[3:0] >= 4'h9) begin
      inc = {value[7:4] + 4'h1, 4'h0};
    end else begin
      inc = {value[7:4], value[3:0] + 4'h1};
    end
    nxt = wrap ? lo : inc;
  end
endmodule : srtc_bcd_step
`default_nettype wire

// >>> srtc_core_properties.sv
// Port-level checks of the serial clock/calendar link
`timescale 1ns/1ns
`default_nettype none
module srtc_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Link pins
  input wire logic transfer_enable_pin,
  input wire logic sclk,
  input wire logic sdata_in,
  input wire logic sdata_out,
  input wire logic sdata_oe
);
  logic sclk_ff;
  logic [3:0] age_ff;
  logic [3:0] nxt_age;
  logic [4:0] rises_ff;
  logic [4:0] nxt_rises;
  // Cycles since a pin fall, rises within the frame
  always_comb begin
    nxt_age = (age_ff == 4'hf) ? age_ff : age_ff + 4'h1;
    nxt_rises = rises_ff;
    if (sclk_ff && !sclk) begin
      nxt_age = 4'h0;
    end
    if (!sclk_ff && sclk && rises_ff != 5'h1f) begin
      nxt_rises = rises_ff + 5'h01;
    end
    if (!transfer_enable_pin) begin
      nxt_rises = 5'h00;
    end
  end
  always_ff @(posedge clk) begin
    sclk_ff <= reset ? 1'b0 : sclk;
    age_ff <= reset ? 4'hf : nxt_age;
    rises_ff <= reset ? 5'h00 : nxt_rises;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  AST_RESET_QUIET: assert property (disable iff (1'b0) reset |=> !sdata_oe && !sdata_out)
    else $error("pin driven after reset");
  AST_IDLE_RELEASE: assert property (!transfer_enable_pin [*5] |-> !sdata_oe)
    else $error("pin driven outside a frame");
  AST_OUT_ZERO_OFF: assert property (!sdata_oe |-> !sdata_out)
    else $error("data high while released");
  AST_OUT_AFTER_FALL: assert property (sdata_oe && $changed(sdata_out) |-> age_ff <= 4'h6)
    else $error("read bit not tied to a falling edge");
  AST_OE_ON_FALL: assert property ($rose(sdata_oe) |-> age_ff <= 4'h6 && transfer_enable_pin)
    else $error("drive began away from a falling edge");
  AST_OE_AFTER_CMD: assert property ($rose(sdata_oe) |-> rises_ff >= 5'h08)
    else $error("drive began before the command byte");
  AST_HOLD_HIGH: assert property ((sclk && transfer_enable_pin) [*5] |-> $stable(sdata_out))
    else $error("read bit moved while clock high");
  AST_OE_DROP_CAUSE: assert property ($fell(sdata_oe) |-> !$past(transfer_enable_pin, 2))
    else $error("drive dropped inside a frame");
  cover property ($rose(sdata_oe));
  cover property (rises_ff == 5'h10 && !sdata_oe);
  cover property ($fell(sdata_oe));
endmodule : srtc_chk
bind srtc_core srtc_chk chk (.clk(clk), .reset(reset), .transfer_enable_pin(transfer_enable_pin),
  .sclk(sclk), .sdata_in(sdata_in), .sdata_out(sdata_out), .sdata_oe(sdata_oe));
`default_nettype wire

// >>> srtc_host_model.sv
// Host model driving the three-wire link
`timescale 1ns/1ns
`default_nettype none
module srtc_host_model (
  // Clock
  input wire logic clk,
  // Device half of the data pin
  input wire logic sdata_out,
  input wire logic sdata_oe,
  // Link toward the device
  output logic enable,
  output logic sclk,
  output logic sdata_in
);
  logic drive = 1'b0;
  logic bit_q = 1'b0;
  logic float_q = 1'b0;
  logic oe_seen = 1'b0;
  logic [7:0] buf_q [8];
  // Released wire shows a changing pattern
  assign sdata_in = sdata_oe ? sdata_out : (drive ? bit_q : float_q);
  always @(posedge clk) begin
    float_q <= !float_q;
    if (sdata_oe) begin
      oe_seen <= 1'b1;
    end
  end
  initial begin
    enable = 1'b0;
    sclk = 1'b0;
  end
  task automatic shift(input logic [7:0] tx, input logic rd, output logic [7:0] rx);
    for (int i = 0; i < 8; i++) begin
      sclk = 1'b0;
      bit_q = tx[i];
      drive = !rd;
      #80;
      sclk = 1'b1;
      rx[i] = sdata_in;
      #80;
    end
  endtask : shift
  task automatic frame(input logic [7:0] cmd, input int n);
    logic [7:0] junk;
    oe_seen = 1'b0;
    enable = 1'b1;
    #80;
    shift(cmd, 1'b0, junk);
    for (int k = 0; k < n; k++) begin
      shift(buf_q[k], cmd[0], buf_q[k]);
    end
    sclk = 1'b0;
    drive = 1'b0;
    #80;
    enable = 1'b0;
    #80;
  endtask : frame
endmodule : srtc_host_model
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the serial clock/calendar
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic enable;
  logic sclk;
  logic sdata_in;
  logic sdata_out;
  logic sdata_oe;
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [7:0] exp_q [8];
  logic [7:0] fmask [8] = '{8'hff, 8'h7f, 8'hbf, 8'h3f, 8'h1f, 8'h0f, 8'hff, 8'h80};
  initial begin
    forever #5 clk = !clk;
  end
  srtc_core #(.SECOND_CYCLES_P(4000)) dut (.clk(clk), .reset(reset),
    .transfer_enable_pin(enable), .sclk(sclk), .sdata_in(sdata_in),
    .sdata_out(sdata_out), .sdata_oe(sdata_oe));
  srtc_host_model host (.clk(clk), .sdata_out(sdata_out), .sdata_oe(sdata_oe),
    .enable(enable), .sclk(sclk), .sdata_in(sdata_in));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
    host.buf_q[0] = d;
    host.frame(cmd, 1);
  endtask : wr
  task automatic rd_chk(input logic [7:0] cmd, input logic [7:0] exp);
    host.frame(cmd, 1);
    chk(host.buf_q[0], exp);
  endtask : rd_chk
  task automatic burst_chk();
    host.frame(8'hbf, 8);
    for (int k = 0; k < 8; k++) begin
      chk(host.buf_q[k], exp_q[k]);
    end
  endtask : burst_chk
  task automatic give_verdict();
    $display("Checks %0d, errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      $display("mismatch at %0t: timeout", $time);
      give_verdict();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    #1 reset = 1'b0;
    // Halted counter must not advance
    repeat (4000) @(posedge clk);
    #1;
    exp_q = '{8'h80, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00};
    burst_chk();
    for (int a = 1; a < 7; a++) begin
      wr({4'h8, a[2:0], 1'b0}, 8'hff);
      rd_chk({4'h8, a[2:0], 1'b1}, fmask[a]);
    end
    wr(8'h8e, 8'hff);
    rd_chk(8'h8f, 8'h80);
    wr(8'h82, 8'h12);
    rd_chk(8'h83, 8'h7f);
    wr(8'h8e, 8'h00);
    // Test and bit7-clear commands get no answer
    host.frame(8'h93, 1);
    chk({7'h0, host.oe_seen}, 8'h00);
    host.frame(8'h03, 1);
    chk({7'h0, host.oe_seen}, 8'h00);
    // Year-end rollover after two seconds
    host.buf_q = '{8'h58, 8'h59, 8'h23, 8'h31, 8'h12, 8'h07, 8'h99, 8'h80};
    host.frame(8'hbe, 8);
    repeat (7600) @(posedge clk);
    #1;
    exp_q = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00};
    burst_chk();
    // 12-hour 11:59:59 PM on 28 Feb of a leap year
    host.buf_q = '{8'h59, 8'h59, 8'hb1, 8'h28, 8'h02, 8'h03, 8'h04, 8'h00};
    host.frame(8'hbe, 8);
    repeat (3600) @(posedge clk);
    #1;
    exp_q = '{8'h00, 8'h00, 8'h92, 8'h29, 8'h02, 8'h04, 8'h04, 8'h00};
    burst_chk();
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
